// File: dv/jtag_host.sv
`timescale 1ns/1ps
// Test host model: the link clock runs only inside frames
module jtag_host (
   // Serial test link
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // One link cycle, tdo read just before the rise
   task cyc(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #23 o = tdo;
      #1 tck = 1'b1;
      #24 tck = 1'b0;
      tdi = ~d; // Released line never shows a stale bit
   endtask

   // Five mode-select highs, then idle
   task rst5;
      logic o;
      repeat (5) cyc(1'b1, 1'b0, o);
      cyc(1'b0, 1'b0, o);
   endtask

   // Whole scan from idle back to idle, LSB first
   task scan(input logic ir, input int n, input logic [127:0] din,
             output logic [127:0] dout);
      logic o;
      dout = '0;
      cyc(1'b1, 1'b0, o);
      if (ir) cyc(1'b1, 1'b0, o);
      cyc(1'b0, 1'b0, o);
      cyc(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) cyc(i == n - 1, din[i], dout[i]);
      cyc(1'b1, 1'b0, o);
      cyc(1'b0, 1'b0, o);
   endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
   $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   import jtag_dbg_pkg::*;
   localparam logic [3:0]  VER  = 4'h3;    // Arbitrary value
   localparam logic [15:0] PART = 16'h1234; // Arbitrary value
   localparam logic [10:0] MFR  = 11'h0A5;  // Arbitrary value
   localparam logic [15:0] REV  = 16'h0002;
   localparam logic [31:0] ID   = {VER, PART, MFR, 1'b1};
   int n_errors = 0, tests_run = 0, nreq = 0, n_dbg = 0, n0, dly = 0;
   logic mclk = 0, rstn = 0, tck, tms, tdi, tdo, tdo_oe_n, dsync_in;
   logic acc_req, acc_we, acc_ack = 0, bsr_drive, dsync_out, dsync_oe_n;
   logic [1:0] acc_tgt, cap_tgt;
   logic [15:0] acc_addr, cap_addr;
   logic [31:0] acc_wdata, acc_rdata = 0, rd = 0, last_rd, cap_wdata;
   logic [7:0] pad_in = 0, bsr_out;
   logic otp_jtag_lock = 0, debug_lock = 0, ext_low = 0, debug_enter;
   logic sync_out_en = 0, sync_in_en = 0, bp_hit = 0, cap_we, pv, pe, pr;
   logic [9:0] uid = 0;
   logic [127:0] o, d;

   // Pin with pull-up, pulled low by either party
   assign dsync_in = ~((~dsync_oe_n & ~dsync_out) | ext_low);

   jtag_debug_port #(.ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR),
                     .SI_REV(REV)) u_dut (
      .mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe_n(tdo_oe_n), .acc_req(acc_req),
      .acc_we(acc_we), .acc_tgt(acc_tgt), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack),
      .pad_in(pad_in), .bsr_out(bsr_out), .bsr_drive(bsr_drive),
      .otp_jtag_lock(otp_jtag_lock), .debug_lock(debug_lock),
      .programmed_user_identifier(uid), .dsync_in(dsync_in),
      .dsync_out(dsync_out), .dsync_oe_n(dsync_oe_n),
      .sync_out_en(sync_out_en), .sync_in_en(sync_in_en),
      .bp_hit(bp_hit), .debug_enter(debug_enter));
   jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   initial begin
      forever #20 mclk = ~mclk;
   end

   // Tile side: answers after a random stall, bus idles inverted
   always @(posedge mclk) begin
      acc_ack <= 1'b0;
      if (acc_req === 1'b1 && !acc_ack) begin
         if (dly == 0) begin
            acc_ack <= 1'b1;
            acc_rdata <= rd;
            last_rd = rd;
            nreq++;
            {cap_we, cap_tgt, cap_addr, cap_wdata} =
               {acc_we, acc_tgt, acc_addr, acc_wdata};
         end else dly <= dly - 1;
      end else begin
         dly <= $urandom % 6;
         rd <= $urandom;
         acc_rdata <= ~rd;
      end
   end

   always @(posedge mclk) begin
      if (debug_enter === 1'b1) n_dbg++;
   end

   task w(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // One access word; checks status of the previous one
   task acc(input logic dbg, input logic we, input logic [1:0] tg,
            input logic lk);
      logic [50:0] wd;
      logic [50:0] st;
      logic        blk;
      wd = {$urandom, 16'($urandom), tg, we};
      blk = lk && tg == TGT_OTP;
      @(posedge mclk) otp_jtag_lock <= lk;
      n0 = nreq;
      u_host.scan(1'b0, 53, dbg ? {wd, 2'b11} : {2'b11, wd}, o);
      st = dbg ? o[52:2] : o[50:0];
      if (pv) `CHK(st[1:0], {pe, 1'b0})
      if (pv && pr) `CHK(st[50:19], last_rd)
      w(30);
      `CHK(nreq - n0, blk ? 0 : 1)
      if (!blk) `CHK({cap_we, cap_tgt, cap_addr, cap_wdata}, {we,
         dbg ? 2'h0 : (tg == 2'h0 ? 2'h1 : tg), wd[18:3], wd[50:19]})
      pv = 1'b1;
      pe = blk;
      pr = !we && !blk;
   endtask

   task summarize;
      if (n_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Watchdog, well beyond the expected run length
   initial begin
      #1000000;
      n_errors++;
      summarize;
   end

   initial begin
      void'($urandom(41));
      @(posedge mclk) uid <= 10'($urandom);
      fork
         begin
            repeat (5) @(posedge mclk);
            rstn <= 1'b1;
         end
         u_host.rst5;
      join
      u_host.rst5;
      u_host.scan(1'b0, 96, '0, o);
      `CHK(o[95:0], {3{ID}})
      `CHK(tdo_oe_n, 1'b1)
      u_host.scan(1'b1, 12, 12'h333, o);
      `CHK(o[11:0], 12'h111)
      u_host.scan(1'b0, 96, '0, o);
      `CHK(o[95:0], {3{uid, 6'h00, REV}})
      u_host.scan(1'b1, 12, 12'hFFF, o);
      d = {$urandom, $urandom, $urandom, $urandom};
      u_host.scan(1'b0, 11, d, o);
      `CHK(o[10:3], d[7:0])
      u_host.rst5;
      u_host.scan(1'b0, 96, '0, o);
      `CHK(o[95:0], {3{ID}})
      // Boundary sample, then drive
      @(posedge mclk) pad_in <= 8'($urandom);
      u_host.scan(1'b1, 12, 12'hF1F, o);
      u_host.scan(1'b0, 10, d, o);
      `CHK(o[8:1], pad_in)
      u_host.scan(1'b1, 12, 12'hF0F, o);
      u_host.scan(1'b0, 10, d, o);
      `CHK({bsr_drive, bsr_out}, {1'b1, d[8:1]})
      // Processor controller: every target, both directions, lock
      u_host.scan(1'b1, 12, 12'hFF8, o);
      pv = 1'b0;
      for (int i = 0; i < 8; i++) acc(1'b0, i[0], i[2:1], 1'b0);
      acc(1'b0, 1'b0, TGT_OTP, 1'b1);
      acc(1'b0, 1'b1, TGT_SWITCH, 1'b1);
      acc(1'b0, 1'b0, TGT_TILE, 1'b0);
      acc(1'b0, 1'b0, TGT_PERIPH, 1'b0);
      // Debug controller always lands on peripherals
      u_host.scan(1'b1, 12, 12'h8FF, o);
      pv = 1'b0;
      acc(1'b1, 1'b1, TGT_SWITCH, 1'b0);
      acc(1'b1, 1'b0, TGT_OTP, 1'b0);
      acc(1'b1, 1'b0, TGT_TILE, 1'b0);
      // Sync pin as output
      @(posedge mclk) sync_out_en <= 1'b1;
      w(3);
      `CHK(dsync_oe_n, 1'b1)
      @(posedge mclk) bp_hit <= 1'b1;
      w(3);
      `CHK(dsync_oe_n, 1'b0)
      @(posedge mclk) debug_lock <= 1'b1;
      w(3);
      `CHK(dsync_oe_n, 1'b1)
      @(posedge mclk) {bp_hit, sync_out_en} <= 2'b00;
      // Sync pin as input: enabled, disabled, locked
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk) {sync_in_en, debug_lock} <= {i != 1, i == 2};
         w(4);
         n0 = n_dbg;
         @(posedge mclk) ext_low <= 1'b1;
         w(8);
         `CHK(n_dbg - n0, i == 0 ? 1 : 0)
         @(posedge mclk) ext_low <= 1'b0;
      end
      w(4);
      summarize;
   end
endmodule

// File: verilog/jtag_dbg_pkg.sv
package jtag_dbg_pkg;

   // Test access controller states, standard walk
   typedef enum logic [3:0] {
      TLR    = 4'h0,
      RTI    = 4'h1,
      SEL_DR = 4'h2,
      CAP_DR = 4'h3,
      SH_DR  = 4'h4,
      EX1_DR = 4'h5,
      PAU_DR = 4'h6,
      EX2_DR = 4'h7,
      UPD_DR = 4'h8,
      SEL_IR = 4'h9,
      CAP_IR = 4'hA,
      SH_IR  = 4'hB,
      EX1_IR = 4'hC,
      PAU_IR = 4'hD,
      EX2_IR = 4'hE,
      UPD_IR = 4'hF
   } tap_state_t;

   // Instruction register and opcodes
   localparam int              IR_W        = 4;
   localparam logic [IR_W-1:0] IR_CAP      = 4'h1;
   localparam logic [IR_W-1:0] IR_EXTEST   = 4'h0;
   localparam logic [IR_W-1:0] IR_SAMPLE   = 4'h1;
   localparam logic [IR_W-1:0] IR_DEVICE_IDENTIFICATION   = 4'h2;
   localparam logic [IR_W-1:0] IR_USER_CODE_WORD = 4'h3;
   localparam logic [IR_W-1:0] IR_ACCESS   = 4'h8;
   localparam logic [IR_W-1:0] IR_BYPASS   = 4'hF;

   // Mode select highs that force reset
   localparam int TMS_RESET_CYCLES = 5;

   // Chain positions, test data in enters at 0
   localparam int N_TAP     = 3;
   localparam int TAP_DEBUG = 0;
   localparam int TAP_BSCAN = 1;
   localparam int TAP_PROC  = 2;

   // Identification and user code layouts
   localparam int ID_W        = 32;
   localparam int ID_VER_W    = 4;
   localparam int ID_PART_W   = 16;
   localparam int ID_MFR_W    = 11;
   localparam int UC_UID_W    = 10;
   localparam int UC_UNUSED_W = 6;
   localparam int UC_REV_W    = 16;

   // Access word layout, shifted in LSB first
   localparam int ACC_WE_BIT   = 0;
   localparam int ACC_TGT_LSB  = 1;
   localparam int ACC_TGT_W    = 2;
   localparam int ACC_ADDR_LSB = 3;
   localparam int ACC_ADDR_W   = 16;
   localparam int ACC_DATA_LSB = 19;
   localparam int ACC_DATA_W   = 32;
   localparam int ACC_W        = 51;
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_ERR_BIT   = 1;

   // Access targets
   localparam logic [ACC_TGT_W-1:0] TGT_PERIPH = 2'h0;
   localparam logic [ACC_TGT_W-1:0] TGT_TILE   = 2'h1;
   localparam logic [ACC_TGT_W-1:0] TGT_SWITCH = 2'h2;
   localparam logic [ACC_TGT_W-1:0] TGT_OTP    = 2'h3;

endpackage

// File: verilog/jtag_debug_port.sv
`timescale 1ns/1ps
// What this block does
// - After reset a tile chains a debug, a boundary and a processor TAP.
// - The debug controller reaches the peripherals, the converter too.
// - The boundary controller follows the standard port and scans pins.
// - The processor controller reaches tile, switch and OTP memory.
// - Mode select held high for five test clocks resets the test logic.
// - The sync pin works both as an output and as an input.
// - In output mode the pin floats until a breakpoint, then goes low.
// - In input mode a low on the pin puts the processor into debug mode.
// - Software picks how the processor reacts to the pin.
// - The identity instruction returns version, part, maker and a fixed one.
// - The user code returns the user id, spare bits and revision.
// - A security bit blocks every test port access to the OTP memory.
// - A security bit disables all use of the sync pin.
module jtag_debug_port
   import jtag_dbg_pkg::*;
#(
   parameter int                   NPINS   = 8,
   parameter logic [ID_VER_W-1:0]  ID_VER  = 4'h1,     // Arbitrary value
   parameter logic [ID_PART_W-1:0] ID_PART = 16'h5A01, // Arbitrary value
   parameter logic [ID_MFR_W-1:0]  ID_MFR  = 11'h2A5,  // Arbitrary value
   parameter logic [UC_REV_W-1:0]  SI_REV  = 16'h0001
) (
   // System clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   // Serial test link
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tdi,
   output logic                       tdo,
   output logic                       tdo_oe_n,
   // Access bus towards the tile
   output logic                       acc_req,
   output logic                       acc_we,
   output logic [ACC_TGT_W-1:0]       acc_tgt,
   output logic [ACC_ADDR_W-1:0]      acc_addr,
   output logic [ACC_DATA_W-1:0]      acc_wdata,
   input  wire logic [ACC_DATA_W-1:0] acc_rdata,
   input  wire logic                  acc_ack,
   // Boundary cells
   input  wire logic [NPINS-1:0]      pad_in,
   output logic [NPINS-1:0]           bsr_out,
   output logic                       bsr_drive,
   // Security bits and user id
   input  wire logic                  otp_jtag_lock,
   input  wire logic                  debug_lock,
   input  wire logic [UC_UID_W-1:0]   programmed_user_identifier,
   // Debug sync pin and processor hooks
   input  wire logic                  dsync_in,
   output logic                       dsync_out,
   output logic                       dsync_oe_n,
   input  wire logic                  sync_out_en,
   input  wire logic                  sync_in_en,
   input  wire logic                  bp_hit,
   output logic                       debug_enter
);

   localparam int LEN_W = $clog2(ACC_W + 1);

   if (NPINS < 1 || NPINS > ACC_W) begin : g_bad
      $error("jtag_debug_port: NPINS out of range");
   end

   // Test clock side state
   typedef struct packed {
      logic                 rs1;
      logic                 rs2;
      logic [NPINS-1:0]     pad1;
      logic [NPINS-1:0]     pad2;
      logic [UC_UID_W-1:0]  uid1;
      logic [UC_UID_W-1:0]  uid2;
      logic                 ack1;
      logic                 ack2;
      logic                 req_tgl;
      logic [ACC_W-1:0]     cmd;
      logic [NPINS-1:0]     bsr;
      logic                 extest;
   } tck_q_t;

   // System clock side state
   typedef struct packed {
      logic                  req1;
      logic                  req2;
      logic                  req3;
      logic                  ack_tgl;
      logic                  pend;
      logic                  we;
      logic [ACC_TGT_W-1:0]  tgt;
      logic [ACC_ADDR_W-1:0] addr;
      logic [ACC_DATA_W-1:0] wdata;
      logic [ACC_DATA_W-1:0] rdata;
      logic                  err;
      logic                  ds1;
      logic                  ds2;
      logic                  ds3;
      logic                  drive;
      logic                  enter;
   } mclk_q_t;

   tck_q_t           tq;
   tck_q_t           next_tq;
   mclk_q_t          mq;
   mclk_q_t          next_mq;
   logic [N_TAP:0]   chain;
   logic [N_TAP-1:0] oe_n_i;
   logic [N_TAP-1:0] upd;
   logic [IR_W-1:0]  ir [N_TAP];
   logic [ACC_W-1:0] dr [N_TAP];
   logic [ACC_W-1:0] cap [N_TAP];
   logic [LEN_W-1:0] len [N_TAP];
   logic [ID_W-1:0]  device_identification;
   logic [ID_W-1:0]  user_code_word;
   logic [ACC_W-1:0] status;
   logic             busy;
   logic             new_cmd;
   logic             otp_hit;

   // Three controllers in series, test data in at position 0
   assign chain[0] = tdi;
   for (genvar g = 0; g < N_TAP; g++) begin : g_tap
      tap_ctrl #(
         .DR_W     (ACC_W),
         .IR_RESET (IR_DEVICE_IDENTIFICATION)
      ) u_tap (
         .tck      (tck),
         .tck_rstn (tq.rs2),
         .tms      (tms),
         .tdi      (chain[g]),
         .tdo      (chain[g+1]),
         .tdo_oe_n (oe_n_i[g]),
         .dr_len   (len[g]),
         .cap_data (cap[g]),
         .ir       (ir[g]),
         .dr       (dr[g]),
         .upd_dr   (upd[g])
      );
   end
   assign tdo      = chain[N_TAP];
   assign tdo_oe_n = oe_n_i[N_TAP-1];

   // Fixed words; bit 0 of the identity is always one
   assign device_identification   = {ID_VER, ID_PART, ID_MFR, 1'b1};
   assign user_code_word = {tq.uid2, UC_UNUSED_W'(0), SI_REV};

   // Busy while the system side has not answered the toggle
   assign busy = tq.req_tgl != tq.ack2;

   // Read data only sampled once the answer has crossed back
   always_comb begin
      status = '0;
      status[ST_BUSY_BIT] = busy;
      if (!busy) begin
         status[ST_ERR_BIT] = mq.err;
         status[ACC_DATA_LSB +: ACC_DATA_W] = mq.rdata;
      end
   end

   // Data register picked by each instruction
   always_comb begin
      for (int i = 0; i < N_TAP; i++) begin
         cap[i] = '0;
         len[i] = LEN_W'(1);
         case (ir[i])
            IR_DEVICE_IDENTIFICATION: begin
               cap[i][ID_W-1:0] = device_identification;
               len[i] = LEN_W'(ID_W);
            end
            IR_USER_CODE_WORD: begin
               cap[i][ID_W-1:0] = user_code_word;
               len[i] = LEN_W'(ID_W);
            end
            IR_EXTEST, IR_SAMPLE: begin
               if (i == TAP_BSCAN) begin
                  cap[i][NPINS-1:0] = tq.pad2;
                  len[i] = LEN_W'(NPINS);
               end
            end
            IR_ACCESS: begin
               if (i != TAP_BSCAN) begin
                  cap[i] = status;
                  len[i] = LEN_W'(ACC_W);
               end
            end
            default: cap[i] = '0;
         endcase
      end
   end

   // Test clock side: synchronisers, command launch, boundary cells
   always_comb begin
      next_tq = tq;
      next_tq.rs1  = rstn;
      next_tq.rs2  = tq.rs1;
      next_tq.pad1 = pad_in;
      next_tq.pad2 = tq.pad1;
      next_tq.uid1 = programmed_user_identifier;
      next_tq.uid2 = tq.uid1;
      next_tq.ack1 = mq.ack_tgl;
      next_tq.ack2 = tq.ack1;
      // A command shifted in while busy is dropped
      for (int i = 0; i < N_TAP; i++) begin
         if (upd[i] && ir[i] == IR_ACCESS && i != TAP_BSCAN
             && !busy) begin
            next_tq.cmd = dr[i];
            next_tq.req_tgl = !tq.req_tgl;
            if (i == TAP_DEBUG) begin
               next_tq.cmd[ACC_TGT_LSB +: ACC_TGT_W] = TGT_PERIPH;
            end else if (dr[i][ACC_TGT_LSB +: ACC_TGT_W]
                         == TGT_PERIPH) begin
               next_tq.cmd[ACC_TGT_LSB +: ACC_TGT_W] = TGT_TILE;
            end
         end
      end
      if (upd[TAP_BSCAN] && (ir[TAP_BSCAN] == IR_EXTEST ||
          ir[TAP_BSCAN] == IR_SAMPLE)) begin
         next_tq.bsr = dr[TAP_BSCAN][NPINS-1:0];
      end
      next_tq.extest = ir[TAP_BSCAN] == IR_EXTEST;
      if (!tq.rs2) begin
         next_tq.req_tgl = 1'b0;
         next_tq.cmd     = '0;
         next_tq.bsr     = '0;
         next_tq.extest  = 1'b0;
      end
   end

   always_ff @(posedge tck) begin
      tq <= next_tq;
   end

   assign bsr_out   = tq.bsr;
   assign bsr_drive = tq.extest;

   // Command seen once its toggle has crossed; cmd is stable by then
   assign new_cmd = mq.req2 != mq.req3;
   assign otp_hit = otp_jtag_lock &&
                    tq.cmd[ACC_TGT_LSB +: ACC_TGT_W] == TGT_OTP;

   // System side: access engine and sync pin
   always_comb begin
      next_mq = mq;
      next_mq.req1 = tq.req_tgl;
      next_mq.req2 = mq.req1;
      next_mq.req3 = mq.req2;
      next_mq.ds1  = dsync_in;
      next_mq.ds2  = mq.ds1;
      next_mq.ds3  = mq.ds2;
      if (new_cmd && otp_hit) begin
         // Locked memory: answer at once, nothing on the bus
         next_mq.err     = 1'b1;
         next_mq.rdata   = '0;
         next_mq.ack_tgl = !mq.ack_tgl;
      end else if (new_cmd) begin
         next_mq.pend  = 1'b1;
         next_mq.err   = 1'b0;
         next_mq.we    = tq.cmd[ACC_WE_BIT];
         next_mq.tgt   = tq.cmd[ACC_TGT_LSB +: ACC_TGT_W];
         next_mq.addr  = tq.cmd[ACC_ADDR_LSB +: ACC_ADDR_W];
         next_mq.wdata = tq.cmd[ACC_DATA_LSB +: ACC_DATA_W];
      end else if (mq.pend && acc_ack) begin
         next_mq.pend    = 1'b0;
         next_mq.ack_tgl = !mq.ack_tgl;
         if (!mq.we) begin
            next_mq.rdata = acc_rdata;
         end
      end
      // Pull low only on a breakpoint, if allowed
      next_mq.drive = sync_out_en && !debug_lock && bp_hit;
      // Falling edge of the pin, ignored while we pull it ourselves
      next_mq.enter = sync_in_en && !debug_lock && !mq.drive &&
                      mq.ds3 && !mq.ds2;
      if (!rstn) begin
         next_mq.ack_tgl = 1'b0;
         next_mq.pend    = 1'b0;
         next_mq.we      = 1'b0;
         next_mq.tgt     = '0;
         next_mq.addr    = '0;
         next_mq.wdata   = '0;
         next_mq.rdata   = '0;
         next_mq.err     = 1'b0;
         next_mq.drive   = 1'b0;
         next_mq.enter   = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      mq <= next_mq;
   end

   assign acc_req     = mq.pend;
   assign acc_we      = mq.we;
   assign acc_tgt     = mq.tgt;
   assign acc_addr    = mq.addr;
   assign acc_wdata   = mq.wdata;
   // Open drain: data stays low, enable low drives it
   assign dsync_out   = 1'b0;
   assign dsync_oe_n  = !mq.drive;
   assign debug_enter = mq.enter;

   a_otp_blocked: assert property (
      @(posedge mclk) disable iff (!rstn)
      (new_cmd && otp_hit) |=> !acc_req && mq.err ##1 !acc_req)
      else $error("OTP access reached the bus while locked");

   a_req_hold: assert property (
      @(posedge mclk) disable iff (!rstn)
      (acc_req && !acc_ack) |=> acc_req && $stable(acc_addr))
      else $error("access request dropped before its answer");

   a_pin_drive: assert property (
      @(posedge mclk) disable iff (!rstn)
      (sync_out_en && !debug_lock && bp_hit) |=> !dsync_oe_n)
      else $error("sync pin not pulled on breakpoint");

   a_pin_float: assert property (
      @(posedge mclk) disable iff (!rstn)
      !bp_hit [*2] |-> dsync_oe_n)
      else $error("sync pin driven without breakpoint");

   a_pin_lock: assert property (
      @(posedge mclk) disable iff (!rstn)
      debug_lock |=> dsync_oe_n && !debug_enter)
      else $error("sync pin used while disabled");

   a_sync_enter: assert property (
      @(posedge mclk) disable iff (!rstn)
      debug_enter |-> $past(sync_in_en) && $past(mq.ds3)
                      && !$past(mq.ds2))
      else $error("debug entry without a falling pin");

   a_device_identification_word: assert property (
      @(posedge tck) disable iff (!tq.rs2)
      ir[TAP_PROC] == IR_DEVICE_IDENTIFICATION |-> cap[TAP_PROC][0]
      && len[TAP_PROC] == LEN_W'(ID_W))
      else $error("identity word malformed");

   a_bscan_update: assert property (
      @(posedge tck) disable iff (!tq.rs2)
      (upd[TAP_BSCAN] && ir[TAP_BSCAN] == IR_EXTEST)
      |=> bsr_out == $past(dr[TAP_BSCAN][NPINS-1:0]) && bsr_drive)
      else $error("boundary cells not updated");

   a_cmd_hold: assert property (
      @(posedge tck) disable iff (!tq.rs2)
      busy |=> $stable(tq.req_tgl) && $stable(tq.cmd))
      else $error("command changed while busy");

   c_access_done: cover property (
      @(posedge mclk) disable iff (!rstn)
      acc_req ##1 !acc_req);

   c_otp_refused: cover property (
      @(posedge mclk) disable iff (!rstn)
      new_cmd && otp_hit);

   c_debug_enter: cover property (
      @(posedge mclk) disable iff (!rstn)
      debug_enter);

   c_extest: cover property (
      @(posedge tck) disable iff (!tq.rs2)
      $rose(bsr_drive));

endmodule

// File: verilog/tap_ctrl.sv
`timescale 1ns/1ps
module tap_ctrl
   import jtag_dbg_pkg::*;
#(
   parameter int              DR_W     = ACC_W,
   parameter logic [IR_W-1:0] IR_RESET = IR_DEVICE_IDENTIFICATION,
   localparam int             LEN_W    = $clog2(DR_W + 1)
) (
   // Link clock and reset
   input  wire logic             tck,
   input  wire logic             tck_rstn,
   // Serial test signals
   input  wire logic             tms,
   input  wire logic             tdi,
   output logic                  tdo,
   output logic                  tdo_oe_n,
   // Data register hooks
   input  wire logic [LEN_W-1:0] dr_len,
   input  wire logic [DR_W-1:0]  cap_data,
   output logic [IR_W-1:0]       ir,
   output logic [DR_W-1:0]       dr,
   output logic                  upd_dr
);

   localparam logic [2:0] ONES_MAX = 3'(TMS_RESET_CYCLES);

   if (DR_W < IR_W || TMS_RESET_CYCLES > 7) begin : g_bad
      $error("tap_ctrl: unsupported parameters");
   end

   typedef struct packed {
      tap_state_t      st;
      logic [2:0]      ones;
      logic [IR_W-1:0] ir;
      logic [DR_W-1:0] sh;
      logic            oe_n;
   } tap_q_t;

   tap_q_t           q;
   tap_q_t           next_q;
   tap_state_t       nst;
   logic [LEN_W-1:0] idx;

   // Newest bit lands at the top of the selected length
   assign idx = dr_len - LEN_W'(1);

   // State walk, one shift register serves IR and DR
   always_comb begin
      next_q = q;
      case (q.st)
         TLR:     nst = tms ? TLR    : RTI;
         RTI:     nst = tms ? SEL_DR : RTI;
         SEL_DR:  nst = tms ? SEL_IR : CAP_DR;
         CAP_DR:  nst = tms ? EX1_DR : SH_DR;
         SH_DR:   nst = tms ? EX1_DR : SH_DR;
         EX1_DR:  nst = tms ? UPD_DR : PAU_DR;
         PAU_DR:  nst = tms ? EX2_DR : PAU_DR;
         EX2_DR:  nst = tms ? UPD_DR : SH_DR;
         UPD_DR:  nst = tms ? SEL_DR : RTI;
         SEL_IR:  nst = tms ? TLR    : CAP_IR;
         CAP_IR:  nst = tms ? EX1_IR : SH_IR;
         SH_IR:   nst = tms ? EX1_IR : SH_IR;
         EX1_IR:  nst = tms ? UPD_IR : PAU_IR;
         PAU_IR:  nst = tms ? EX2_IR : PAU_IR;
         EX2_IR:  nst = tms ? UPD_IR : SH_IR;
         UPD_IR:  nst = tms ? SEL_DR : RTI;
         default: nst = TLR;
      endcase
      // Count of mode select highs, forced reset on the last
      if (!tms) begin
         next_q.ones = 3'h0;
      end else if (q.ones != ONES_MAX) begin
         next_q.ones = q.ones + 3'h1;
      end
      if (tms && q.ones >= ONES_MAX - 3'h1) begin
         nst = TLR;
      end
      next_q.st = nst;
      case (q.st)
         CAP_IR: next_q.sh = DR_W'(IR_CAP);
         SH_IR: begin
            next_q.sh = q.sh >> 1;
            next_q.sh[IR_W-1] = tdi;
         end
         CAP_DR: next_q.sh = cap_data;
         SH_DR: begin
            next_q.sh = q.sh >> 1;
            next_q.sh[idx] = tdi;
         end
         UPD_IR:  next_q.ir = q.sh[IR_W-1:0];
         TLR:     next_q.ir = IR_RESET;
         default: next_q.ir = q.ir;
      endcase
      // Drive test data out only while shifting
      next_q.oe_n = !(nst == SH_DR || nst == SH_IR);
      if (!tck_rstn) begin
         next_q      = '0;
         next_q.st   = TLR;
         next_q.ir   = IR_RESET;
         next_q.oe_n = 1'b1;
      end
   end

   always_ff @(posedge tck) begin
      q <= next_q;
   end

   // Bit 0 is already a flop, so no extra output stage
   assign tdo      = q.sh[0];
   assign tdo_oe_n = q.oe_n;
   assign ir       = q.ir;
   assign dr       = q.sh;
   assign upd_dr   = (q.st == UPD_DR);

   a_mode_reset: assert property (
      @(posedge tck) disable iff (!tck_rstn)
      tms [*5] |=> q.st == TLR)
      else $error("no reset after five mode select highs");

   a_ir_default: assert property (
      @(posedge tck) disable iff (!tck_rstn)
      q.st == TLR |=> ir == IR_RESET)
      else $error("instruction not defaulted in reset state");

   a_shift_path: assert property (
      @(posedge tck) disable iff (!tck_rstn)
      (q.st == SH_DR && dr_len > LEN_W'(1))
      |=> tdo == $past(q.sh[1]) && q.sh[$past(idx)] == $past(tdi))
      else $error("data register did not shift by one");

   c_ir_update: cover property (
      @(posedge tck) disable iff (!tck_rstn)
      q.st == UPD_IR ##1 q.st == RTI);

endmodule
